// *** verilog/rpb_pkg.sv ***
// package: constants and types of the reset precedence and boot vector block
package rpb_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_SWITCH_CTL = 8'h00;
  localparam logic [7:0] OFS_BOOT_STATUS = 8'h04;
  localparam logic [7:0] OFS_PORT_CLK_MODE = 8'h08;
  localparam logic [7:0] OFS_PART_CTL = 8'h0C;
  localparam logic [7:0] OFS_UP_BRIDGE_CTL = 8'h10;
  localparam logic [7:0] OFS_DN_BRIDGE_CTL = 8'h14;
  localparam logic [7:0] OFS_PORT_CTL = 8'h18;
  localparam logic [7:0] OFS_PART_STATUS = 8'h1C;
  localparam logic [7:0] OFS_PORT_STATUS = 8'h20;
  localparam logic [7:0] OFS_STICKY = 8'h24;
  localparam logic [7:0] OFS_PERSIST = 8'h28;
  localparam logic [7:0] OFS_PORT_MAP = 8'h2C;

  // ==========================================================
  // field positions and reset values
  localparam int CTL_HOLD_BIT = 0;
  localparam int CTL_UNLOCK_BIT = 1;
  localparam int PERSIST_LO = 0;
  localparam int UNLOCKED_LO = 16;
  localparam logic [15:0] RST_PERSIST = 16'h0000;
  localparam logic [15:0] RST_UNLOCKED = 16'h0000;
  localparam logic [7:0] RST_STICKY = 8'h00;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;

  // ==========================================================
  // priority numbers, lower wins
  localparam logic [3:0] PRI_NONE = 4'h0;
  localparam logic [3:0] PRI_GLOBAL = 4'h1;
  localparam logic [3:0] PRI_PORT_MODE = 4'h2;
  localparam logic [3:0] PRI_PART_PIN = 4'h3;
  localparam logic [3:0] PRI_PART_STATE = 4'h4;
  localparam logic [3:0] PRI_HOT_TS1 = 4'h5;
  localparam logic [3:0] PRI_DL_DOWN = 4'h6;
  localparam logic [3:0] PRI_UP_SBR = 4'h7;
  localparam logic [3:0] PRI_DN_SBR = 4'h8;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    RT_NONE = 3'h0,
    RT_SWITCH_FUND = 3'h1,
    RT_PORT_MODE = 3'h2,
    RT_PART_FUND = 3'h3,
    RT_PART_HOT = 3'h4,
    RT_UP_SBR = 3'h5,
    RT_DN_SBR = 3'h6
  } rpb_rst_e;

  typedef enum logic [1:0] {
    ST_FUND = 2'h0,
    ST_HALT = 2'h1,
    ST_RUN = 2'h3
  } rpb_state_e;

  typedef struct packed {
    logic gclk_freq;
    logic [2:0] clk_mode;
    logic [3:0] merge;
    logic reset_hold;
    logic [1:0] slave_addr;
    logic [3:0] op_mode;
  } rpb_boot_vec_s;

  localparam rpb_boot_vec_s BVEC_RESET = 15'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rpb_bus_req_s;

endpackage

// *** verilog/rpb_reset_seq.sv ***
// reset precedence arbiter, register classes and boot vector capture
// Contract
// RL1: concurrent causes resolve to lowest priority number; global pin is top priority.
// RL2: port mode change resets port at priority two only when action selects reset.
// RL3: partition fundamental reset from its pin (three) or state field (four).
// RL4: partition hot reset from hot-reset TS1 (five) or DL_Down (six).
// RL5: upstream secondary bus reset bit is seven, downstream port bit is eight.
// RL6: switch reset hits all, partition reset its ports, port reset one port.
// RL7: when higher cause ends, move at once to remaining lower cause's type.
// RL8: same reset type on both causes means staying in reset without release.
// RL9: switch-persist fields reinitialise only on whole-device fundamental reset.
// RL10: sticky fields reinitialise on device or partition fundamental reset only.
// RL11: unlock-writable fields act switch-persist, surviving all but device reset.
// RL12: straps are sampled only in device reset; otherwise pins are ignored.
// RL13: captured straps stay readable in the boot vector status register.
// RL14: global clock frequency strap is fixed after sampling.
// RL15: clock mode strap seeds port clock mode; software may override it.
// RL16: four fixed merge straps each merge one adjacent port pair.
// RL17: hold strap keeps device in reset after release with SMBus sides active.
// RL18: device leaves held reset only when SMBus master clears the hold bit.
// RL19: two fixed strap bits give the slave bus address variable bits.
// RL20: four fixed strap bits pick the operating mode used after reset.
// RL21: straps captured as global pin releases, then registers take defaults.
// RL22: while held, ports retry type 0 config, discard others, return credits.
// RL23: reset pins pass a two-flop synchroniser before arbitration.
module rpb_reset_seq
#(
  parameter int NPORT = 8,
  parameter int NPART = 2
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // reset causes
  input wire logic i_global_reset_n,
  input wire logic [NPART-1:0] i_partition_reset_pin_n,
  input wire logic [NPART-1:0] i_hot_reset_ts1,
  input wire logic [NPART-1:0] i_dl_down,
  input wire logic [NPORT-1:0] i_port_mode_change,
  // strap pins
  input wire rpb_pkg::rpb_boot_vec_s i_straps,
  // register port
  input wire rpb_pkg::rpb_bus_req_s i_bus,
  output logic [31:0] o_rdata,
  // reset outputs
  output logic o_switch_reset,
  output logic o_quasi_reset,
  output logic o_smbus_active,
  output logic [NPART-1:0][2:0] o_part_rst_type,
  output logic [NPORT-1:0][2:0] o_port_rst_type,
  // boot configuration
  output rpb_pkg::rpb_boot_vec_s o_boot_vec,
  output logic [2:0] o_port_clock_mode
);
  import rpb_pkg::*;

  localparam int PART_W = (NPART > 1) ? $clog2(NPART) : 1;

  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] nrst_sync_ff;
  logic rst_n;
  logic [1:0] gsync_ff;
  logic gsync_d_ff;
  logic [NPART-1:0] psync0_ff;
  logic [NPART-1:0] psync1_ff;
  logic gl_rel;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      nrst_sync_ff <= 2'h0;
    else
      nrst_sync_ff <= {nrst_sync_ff[0], 1'b1};
  end
  assign rst_n = nrst_sync_ff[1];

  // pins start as asserted so a power-on always passes a capture edge
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gsync_ff <= 2'h0;
      gsync_d_ff <= 1'b0;
      psync0_ff <= '0;
      psync1_ff <= '0;
    end
    else
    begin
      gsync_ff <= {gsync_ff[0], i_global_reset_n}; // see RL23
      gsync_d_ff <= gsync_ff[1];
      psync0_ff <= i_partition_reset_pin_n; // see RL23
      psync1_ff <= psync0_ff;
    end
  end
  assign gl_rel = gsync_ff[1] & ~gsync_d_ff;

  // ==========================================================
  // device state
  rpb_state_e state_ff;
  rpb_state_e nxt_state;
  logic hold_ff;
  logic in_fund;

  assign in_fund = (state_ff == ST_FUND);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_FUND:
        if (gl_rel)
          nxt_state = i_straps.reset_hold ? ST_HALT : ST_RUN; // see RL17
      ST_HALT:
        if (!hold_ff)
          nxt_state = ST_RUN; // see RL18
      ST_RUN:
        if (hold_ff)
          nxt_state = ST_HALT;
      default:
        nxt_state = ST_FUND;
    endcase
    if (!gsync_ff[1])
      nxt_state = ST_FUND; // see RL1
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_FUND;
      o_switch_reset <= 1'b1;
      o_quasi_reset <= 1'b0;
      o_smbus_active <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      o_switch_reset <= (nxt_state == ST_FUND);
      o_quasi_reset <= (nxt_state == ST_HALT); // see RL22
      o_smbus_active <= (nxt_state != ST_FUND); // see RL17
    end
  end

  // ==========================================================
  // boot vector capture
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_boot_vec <= BVEC_RESET;
    else if (gl_rel)
      o_boot_vec <= i_straps; // see RL12 see RL14 see RL16 see RL19 see RL20 see RL21
  end

  // ==========================================================
  // register writes; writes during device reset are dropped
  logic wr_ok;
  logic unlock_ff;
  logic [NPART-1:0] part_state_ff;
  logic [NPART-1:0] up_sbr_ff;
  logic [NPORT-1:0] dn_sbr_ff;
  logic [NPORT-1:0] oma_ff;
  logic [NPORT*PART_W-1:0] map_ff;
  logic [15:0] persist_ff;
  logic [15:0] unlocked_ff;
  logic [NPART-1:0][7:0] sticky_ff;
  logic [NPART-1:0][2:0] part_type;
  logic [NPART-1:0][3:0] part_prio;
  logic [NPORT-1:0][2:0] port_type;
  logic [NPORT-1:0][3:0] port_prio;
  logic [NPART-1:0][3:0] part_prio_ff;
  logic [NPORT-1:0][3:0] port_prio_ff;

  assign wr_ok = i_bus.wr & ~in_fund;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_ff <= 1'b0;
    else if (gl_rel)
      hold_ff <= i_straps.reset_hold; // see RL17
    else if (in_fund)
      hold_ff <= 1'b0;
    else if (wr_ok && i_bus.addr == OFS_SWITCH_CTL)
      hold_ff <= i_bus.wdata[CTL_HOLD_BIT]; // see RL18
  end

  // unlock opens in device reset and closes once normal running starts
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      unlock_ff <= 1'b1;
    else if (in_fund)
      unlock_ff <= 1'b1;
    else if (nxt_state == ST_RUN)
      unlock_ff <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_port_clock_mode <= 3'h0;
    else if (gl_rel)
      o_port_clock_mode <= i_straps.clk_mode; // see RL15
    else if (wr_ok && i_bus.addr == OFS_PORT_CLK_MODE)
      o_port_clock_mode <= i_bus.wdata[2:0]; // see RL15
  end

  // control bits of the reset causes
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      part_state_ff <= '0;
      up_sbr_ff <= '0;
      dn_sbr_ff <= '0;
      oma_ff <= '0;
      map_ff <= '0;
    end
    else if (in_fund)
    begin
      part_state_ff <= '0;
      up_sbr_ff <= '0;
      dn_sbr_ff <= '0;
      oma_ff <= '0;
      map_ff <= '0;
    end
    else if (wr_ok)
    begin
      if (i_bus.addr == OFS_PART_CTL)
        part_state_ff <= i_bus.wdata[NPART-1:0];
      if (i_bus.addr == OFS_UP_BRIDGE_CTL)
        up_sbr_ff <= i_bus.wdata[NPART-1:0];
      if (i_bus.addr == OFS_DN_BRIDGE_CTL)
        dn_sbr_ff <= i_bus.wdata[NPORT-1:0];
      if (i_bus.addr == OFS_PORT_CTL)
        oma_ff <= i_bus.wdata[NPORT-1:0];
      if (i_bus.addr == OFS_PORT_MAP)
        map_ff <= i_bus.wdata[NPORT*PART_W-1:0];
    end
  end

  // switch-persist and unlock-writable fields: only device reset clears them
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      persist_ff <= RST_PERSIST;
      unlocked_ff <= RST_UNLOCKED;
    end
    else if (in_fund)
    begin
      persist_ff <= RST_PERSIST; // see RL9
      unlocked_ff <= RST_UNLOCKED; // see RL11
    end
    else if (wr_ok && i_bus.addr == OFS_PERSIST)
    begin
      persist_ff <= i_bus.wdata[PERSIST_LO +: 16];
      if (unlock_ff)
        unlocked_ff <= i_bus.wdata[UNLOCKED_LO +: 16]; // see RL11
    end
  end

  // ==========================================================
  // per-partition arbitration and sticky fields
  genvar gp;
  for (gp = 0; gp < NPART; gp++)
  begin : g_part
    rpb_rst_e typ;
    logic [3:0] pri;
    // one fixed ladder: recomputed every cycle, so a lower cause takes over
    // in the cycle the higher one drops, and equal types never release
    always_comb
    begin
      typ = RT_NONE;
      pri = PRI_NONE;
      if (in_fund)
      begin
        typ = RT_SWITCH_FUND; // see RL1 see RL6
        pri = PRI_GLOBAL;
      end
      else if (!psync1_ff[gp])
      begin
        typ = RT_PART_FUND; // see RL3
        pri = PRI_PART_PIN;
      end
      else if (part_state_ff[gp])
      begin
        typ = RT_PART_FUND; // see RL3 see RL8
        pri = PRI_PART_STATE;
      end
      else if (i_hot_reset_ts1[gp])
      begin
        typ = RT_PART_HOT; // see RL4
        pri = PRI_HOT_TS1;
      end
      else if (i_dl_down[gp])
      begin
        typ = RT_PART_HOT; // see RL4 see RL7
        pri = PRI_DL_DOWN;
      end
      else if (up_sbr_ff[gp])
      begin
        typ = RT_UP_SBR; // see RL5
        pri = PRI_UP_SBR;
      end
    end
    assign part_type[gp] = typ;
    assign part_prio[gp] = pri;

    always_ff @(posedge i_clk or negedge rst_n)
    begin
      if (!rst_n)
        sticky_ff[gp] <= RST_STICKY;
      else if (typ == RT_SWITCH_FUND || typ == RT_PART_FUND)
        sticky_ff[gp] <= RST_STICKY; // see RL10
      else if (wr_ok && i_bus.addr == OFS_STICKY)
        sticky_ff[gp] <= i_bus.wdata[gp*8 +: 8];
    end
  end

  // ==========================================================
  // per-port arbitration; a partition reset spreads to its mapped ports
  genvar gq;
  for (gq = 0; gq < NPORT; gq++)
  begin : g_port
    rpb_rst_e typ;
    logic [3:0] pri;
    logic [PART_W-1:0] idx;
    assign idx = map_ff[gq*PART_W +: PART_W];
    always_comb
    begin
      typ = RT_NONE;
      pri = PRI_NONE;
      if (in_fund)
      begin
        typ = RT_SWITCH_FUND; // see RL1
        pri = PRI_GLOBAL;
      end
      else if (i_port_mode_change[gq] && oma_ff[gq])
      begin
        typ = RT_PORT_MODE; // see RL2 see RL6
        pri = PRI_PORT_MODE;
      end
      else if (int'(idx) < NPART && part_type[idx] != RT_NONE)
      begin
        typ = rpb_rst_e'(part_type[idx]); // see RL6
        pri = part_prio[idx];
      end
      else if (dn_sbr_ff[gq])
      begin
        typ = RT_DN_SBR; // see RL5
        pri = PRI_DN_SBR;
      end
    end
    assign port_type[gq] = typ;
    assign port_prio[gq] = pri;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_part_rst_type <= {NPART{RT_SWITCH_FUND}};
      o_port_rst_type <= {NPORT{RT_SWITCH_FUND}};
      part_prio_ff <= {NPART{PRI_GLOBAL}};
      port_prio_ff <= {NPORT{PRI_GLOBAL}};
    end
    else
    begin
      o_part_rst_type <= part_type;
      o_port_rst_type <= port_type;
      part_prio_ff <= part_prio;
      port_prio_ff <= port_prio;
    end
  end

  // ==========================================================
  // register reads, one cycle after the strobe; unmapped reads return zero
  logic [31:0] rd_val;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (i_bus.addr)
      OFS_SWITCH_CTL: rd_val = 32'({unlock_ff, hold_ff});
      OFS_BOOT_STATUS: rd_val = 32'(o_boot_vec); // see RL13
      OFS_PORT_CLK_MODE: rd_val = 32'(o_port_clock_mode);
      OFS_PART_CTL: rd_val = 32'(part_state_ff);
      OFS_UP_BRIDGE_CTL: rd_val = 32'(up_sbr_ff);
      OFS_DN_BRIDGE_CTL: rd_val = 32'(dn_sbr_ff);
      OFS_PORT_CTL: rd_val = 32'(oma_ff);
      OFS_PART_STATUS: rd_val = 32'(part_prio_ff);
      OFS_PORT_STATUS: rd_val = 32'(port_prio_ff);
      OFS_STICKY: rd_val = 32'(sticky_ff);
      OFS_PERSIST: rd_val = {unlocked_ff, persist_ff};
      OFS_PORT_MAP: rd_val = 32'(map_ff);
      default: rd_val = RST_CTRL;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= RST_CTRL;
    else if (i_bus.rd)
      o_rdata <= rd_val;
    else
      o_rdata <= RST_CTRL;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  property p_global_top;
    in_fund |=> o_port_rst_type[0] == RT_SWITCH_FUND && port_prio_ff[0] == PRI_GLOBAL;
  endproperty
  a_global_top: assert property (p_global_top) else $error("device reset lost"); // see RL1

  property p_port_mode;
    !in_fund && i_port_mode_change[0] && oma_ff[0]
      |=> o_port_rst_type[0] == RT_PORT_MODE && port_prio_ff[0] == PRI_PORT_MODE;
  endproperty
  a_port_mode: assert property (p_port_mode) else $error("port mode reset missed"); // see RL2

  property p_part_pin;
    !in_fund && !psync1_ff[0] |=> o_part_rst_type[0] == RT_PART_FUND && part_prio_ff[0] == 4'h3;
  endproperty
  a_part_pin: assert property (p_part_pin) else $error("partition pin reset wrong"); // see RL3

  property p_hot_ts1;
    !in_fund && psync1_ff[0] && !part_state_ff[0] && i_hot_reset_ts1[0]
      |=> o_part_rst_type[0] == RT_PART_HOT && part_prio_ff[0] == 4'h5;
  endproperty
  a_hot_ts1: assert property (p_hot_ts1) else $error("hot reset priority wrong"); // see RL4

  property p_up_sbr;
    !in_fund && psync1_ff[0] && !part_state_ff[0] && !i_hot_reset_ts1[0] && !i_dl_down[0]
      && up_sbr_ff[0] |=> part_prio_ff[0] == 4'h7;
  endproperty
  a_up_sbr: assert property (p_up_sbr) else $error("upstream bus reset wrong"); // see RL5

  property p_straps_frozen;
    !gl_rel |=> $stable(o_boot_vec);
  endproperty
  a_straps_frozen: assert property (p_straps_frozen) else $error("straps moved"); // see RL12

  property p_boot_read;
    i_bus.rd && i_bus.addr == OFS_BOOT_STATUS && !gl_rel |=> o_rdata[14:0] == o_boot_vec;
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot status mismatch"); // see RL13

  property p_persist;
    !in_fund && !(i_bus.wr && i_bus.addr == OFS_PERSIST) |=> $stable(persist_ff);
  endproperty
  a_persist: assert property (p_persist) else $error("persist field changed"); // see RL9

  property p_sticky;
    part_type[0] == RT_PART_FUND |=> sticky_ff[0] == RST_STICKY;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky not cleared"); // see RL10

  property p_hold_entry;
    gl_rel && i_straps.reset_hold |=> o_quasi_reset && o_smbus_active && !o_switch_reset;
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("hold not entered"); // see RL17

  property p_hold_release;
    state_ff == ST_HALT && gsync_ff[1] && hold_ff |=> o_quasi_reset;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("left hold early"); // see RL18

  property p_clk_seed;
    gl_rel |=> o_port_clock_mode == $past(i_straps.clk_mode);
  endproperty
  a_clk_seed: assert property (p_clk_seed) else $error("clock mode not seeded"); // see RL15

  c_release: cover property (state_ff == ST_HALT ##1 state_ff == ST_RUN);
  c_port_mode: cover property (o_port_rst_type[0] == RT_PORT_MODE);
  c_hot_to_sbr: cover property (part_prio_ff[0] == 4'h5 ##1 part_prio_ff[0] == 4'h7);

endmodule // rpb_reset_seq

// *** sim/rpb_board_model.sv ***
// board side model: global reset pin and strap pins
module rpb_board_model
(
  // clock
  input wire logic i_clk,
  // bench commands
  input wire logic i_pin_low,
  input wire rpb_pkg::rpb_boot_vec_s i_strap_val,
  // pins seen by the switch
  output logic o_global_reset_n,
  output rpb_pkg::rpb_boot_vec_s o_straps
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpb_pkg::*;
  logic [3:0] hold_cnt_ff;
  initial
  begin
    o_global_reset_n = 1'b0;
    o_straps = i_strap_val;
    hold_cnt_ff = 4'h8;
  end
  // ==========================================================
  // pin and strap drive
  always @(posedge i_clk)
  begin
    o_global_reset_n <= ~i_pin_low;
    if (i_pin_low)
      hold_cnt_ff <= 4'h8;
    else if (hold_cnt_ff != 4'h0)
      hold_cnt_ff <= hold_cnt_ff - 4'h1;
    // straps stand across the pin release, then flip every cycle so a late sample shows
    if (i_pin_low || hold_cnt_ff != 4'h0)
      o_straps <= i_strap_val;
    else
      o_straps <= ~o_straps;
  end
endmodule // rpb_board_model

// *** sim/testbench.sv ***
// self-checking bench for the reset precedence and boot vector block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rpb_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic pin_low = 1'b1;
  rpb_boot_vec_s strap_val = '0;
  logic global_reset_n;
  rpb_boot_vec_s straps;
  logic [1:0] part_pin_n = 2'b11;
  logic [1:0] ts1 = 2'b00;
  logic [1:0] dl_down = 2'b00;
  logic [7:0] mode_chg = 8'h00;
  rpb_bus_req_s bus = '0;
  logic [31:0] rdata;
  logic sw_rst;
  logic quasi;
  logic smb;
  logic [1:0][2:0] part_type;
  logic [7:0][2:0] port_type;
  rpb_boot_vec_s boot_vec;
  logic [2:0] pclk;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [31:0] keep;
  logic [8:0] m = '0;

  always #2 i_clk = ~i_clk;

  rpb_board_model board_u (.i_clk(i_clk), .i_pin_low(pin_low), .i_strap_val(strap_val),
    .o_global_reset_n(global_reset_n), .o_straps(straps));

  rpb_reset_seq #(.NPORT(8), .NPART(2)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_global_reset_n(global_reset_n), .i_partition_reset_pin_n(part_pin_n),
    .i_hot_reset_ts1(ts1), .i_dl_down(dl_down), .i_port_mode_change(mode_chg),
    .i_straps(straps), .i_bus(bus), .o_rdata(rdata), .o_switch_reset(sw_rst),
    .o_quasi_reset(quasi), .o_smbus_active(smb), .o_part_rst_type(part_type),
    .o_port_rst_type(port_type), .o_boot_vec(boot_vec), .o_port_clock_mode(pclk));

  // ==========================================================
  // expectation helpers
  function automatic logic [3:0] exp_pri(input logic [8:0] mk);
    exp_pri = 4'h0;
    for (int i = 8; i >= 1; i--)
      if (mk[i])
        exp_pri = 4'(i);
  endfunction

  function automatic logic [2:0] pri_type(input logic [3:0] p);
    case (p)
      4'h1: pri_type = RT_SWITCH_FUND;
      4'h2: pri_type = RT_PORT_MODE;
      4'h3, 4'h4: pri_type = RT_PART_FUND;
      4'h5, 4'h6: pri_type = RT_PART_HOT;
      4'h7: pri_type = RT_UP_SBR;
      4'h8: pri_type = RT_DN_SBR;
      default: pri_type = RT_NONE;
    endcase
  endfunction

  // ==========================================================
  // checks, bus cycles and waits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge i_clk);
    bus <= '{1'b1, 1'b0, a, dt};
    @(posedge i_clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] dt);
    @(posedge i_clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge i_clk);
    bus <= '0;
    #1;
    dt = rdata;
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (sw_rst !== 1'b0 && n < 30)
    begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(2);
    chk(n < 30, 1'b1, "left reset");
  endtask

  // port 0 sees every cause, port 1 and partition 0 only the partition ones
  task automatic set_cause(input int k, input logic on);
    @(posedge i_clk);
    case (k)
      2: mode_chg[0] <= on;
      3: part_pin_n[0] <= ~on;
      4: bus_wr(OFS_PART_CTL, {31'h0, on});
      5: ts1[0] <= on;
      6: dl_down[0] <= on;
      7: bus_wr(OFS_UP_BRIDGE_CTL, {31'h0, on});
      default: bus_wr(OFS_DN_BRIDGE_CTL, {31'h0, on});
    endcase
    m[k] = on;
    wait_cyc(6);
  endtask

  task automatic chk_ladder();
    logic [3:0] pp;
    pp = exp_pri(m & 9'h0F8);
    chk(port_type[0], pri_type(exp_pri(m)), "port0 type");
    chk(port_type[1], pri_type(pp), "port1 type");
    chk(part_type[0], pri_type(pp), "part0 type");
    chk(part_type[1], RT_NONE, "part1 type");
    chk(port_type[2], RT_NONE, "port2 other partition");
    bus_rd(OFS_PORT_STATUS, d);
    chk(d[7:0], {pp, exp_pri(m)}, "port prio");
  endtask

  // ==========================================================
  // timeout
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'he7c4));
    strap_val = rpb_boot_vec_s'($urandom);
    strap_val.reset_hold = 1'b1;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    wait_cyc(6);
    @(posedge i_clk);
    pin_low <= 1'b0;
    wait_run();
    chk(quasi, 1'b1, "held");
    chk(smb, 1'b1, "smbus up");
    chk(boot_vec, strap_val, "captured");
    chk(pclk, strap_val.clk_mode, "clk mode seed");
    bus_rd(OFS_BOOT_STATUS, d);
    chk(d, {17'h0, strap_val}, "boot status");
    wait_cyc(1);
    chk(rdata, 32'h0000_0000, "read data gone");
    keep = $urandom;
    bus_wr(OFS_PERSIST, keep);
    bus_wr(OFS_STICKY, 32'h0000_A55A);
    bus_rd(8'hFC, d);
    chk(d, 32'h0000_0000, "unmapped");
    wait_cyc(12);
    chk(boot_vec, strap_val, "straps ignored");
    bus_wr(OFS_SWITCH_CTL, 32'h0000_0000);
    wait_cyc(3);
    chk(quasi, 1'b0, "released");
    // locked now: the upper half must refuse the write
    bus_wr(OFS_PERSIST, ~keep);
    d = {29'h0, 3'($urandom)};
    bus_wr(OFS_PORT_CLK_MODE, d);
    wait_cyc(2);
    chk(pclk, d[2:0], "clk mode override");
    @(posedge i_clk);
    mode_chg[0] <= 1'b1;
    wait_cyc(6);
    chk(port_type[0], RT_NONE, "action off");
    @(posedge i_clk);
    mode_chg[0] <= 1'b0;
    bus_wr(OFS_PORT_CTL, 32'h0000_0001);
    // port 2 moves to partition 1, so partition 0 causes must not reach it
    bus_wr(OFS_PORT_MAP, 32'h0000_0004);
    for (int k = 8; k >= 2; k--)
    begin
      set_cause(k, 1'b1);
      chk_ladder();
    end
    for (int k = 2; k <= 8; k++)
    begin
      set_cause(k, 1'b0);
      chk_ladder();
    end
    bus_rd(OFS_STICKY, d);
    chk(d[15:0], 16'hA500, "sticky cleared");
    bus_rd(OFS_PERSIST, d);
    chk(d, {keep[31:16], ~keep[15:0]}, "persist kept");
    strap_val = rpb_boot_vec_s'($urandom);
    strap_val.reset_hold = 1'b0;
    @(posedge i_clk);
    ts1[0] <= 1'b1;
    pin_low <= 1'b1;
    wait_cyc(6);
    chk(sw_rst, 1'b1, "fund reset");
    chk(port_type[0], RT_SWITCH_FUND, "fund wins");
    chk(smb, 1'b0, "smbus down");
    @(posedge i_clk);
    pin_low <= 1'b0;
    wait_run();
    chk(quasi, 1'b0, "no hold");
    chk(boot_vec, strap_val, "recaptured");
    chk(port_type[0], RT_PART_HOT, "hot takes over");
    bus_rd(OFS_PERSIST, d);
    chk(d, {RST_UNLOCKED, RST_PERSIST}, "persist init");
    end_of_test();
  end
endmodule // testbench
